/* verilog/iood_pkg.sv */
// Purpose: Shared constants and carrier types for the indexed offset operand decoder
// Assumes: 14-bit data space, 8-bit data path, 16-bit instruction words
// Notes:   Field positions and opcode patterns are named here once
package iood_pkg;

   localparam int ADDR_W     = 14;
   localparam int DATA_W     = 8;
   localparam int INSN_W     = 16;

   // Instruction word field positions
   localparam int OP_HI      = 15;
   localparam int OP6_LO     = 10;
   localparam int OP4_LO     = 12;
   localparam int OP8_LO     = 8;
   localparam int DEST_BIT   = 9;
   localparam int ACC_BIT    = 8;
   localparam int BIT_HI     = 11;
   localparam int BIT_LO     = 9;
   localparam int OFS_HI     = 7;

   // Opcode patterns
   localparam logic [5:0] OPC_ADD6   = 6'h09;  // 0010 01
   localparam logic [3:0] OPC_BSET4  = 4'h8;   // 1000
   localparam logic [7:0] OPC_FILL8  = 8'h68;  // 0110 1000 (access bit clear)
   localparam logic [7:0] OPC_FILL8A = 8'h69;  // Banked fill-ones form

   // Addressing constants
   localparam logic [7:0] IDX_LIMIT  = 8'h5F;
   localparam logic [7:0] FILL_VAL   = 8'hFF;
   localparam logic [3:0] NIB_MASK   = 4'hF;
   localparam logic [5:0] ACC_HI_PAGE = 6'h3F; // Upper access half maps to top page
   localparam logic [7:0] ACC_SPLIT  = 8'h60;
   localparam logic [13:0] RST_ADDR  = 14'h0000;
   localparam logic [7:0]  RST_BYTE  = 8'h00;

   typedef enum logic [1:0] {
      IOOD_OP_NONE,
      IOOD_OP_ADD,
      IOOD_OP_BSET,
      IOOD_OP_FILL
   } iood_op_type;

   // Decoded operand carrier
   typedef struct packed {
      iood_op_type       op;
      logic [13:0]       addr;
      logic              dest_file;
      logic [2:0]        bit_sel;
      logic              indexed;
   } iood_dec_type;

   // Status flags carrier
   typedef struct packed {
      logic n;
      logic overflow_flag;
      logic z;
      logic digit_carry_flag;
      logic c;
   } iood_flags_type;

endpackage : iood_pkg

/* verilog/iood_addr_gen.sv */
// Purpose: Effective address former for file-register operands
// Assumes: Purely combinational, evaluated within the decode cycle
// Notes:   Output is registered by the instantiating module
`timescale 1ns/1ps
module iood_addr_gen (
   input  wire logic [7:0]  f_i,
   input  wire logic        acc_bank_sel_i,
   input  wire logic        ext_en_i,
   input  wire logic [13:0] stack_frame_pointer_i,
   input  wire logic [5:0]  bank_select_reg_i,
   output logic [13:0]      addr_o,
   output logic             indexed_o
);

   // Frame pointer plus zero-extended offset
   function automatic logic [13:0] iood_idx_sum(input logic [13:0] base,
                                                input logic [7:0]  ofs);
      iood_idx_sum = base + {6'h00, ofs};
   endfunction : iood_idx_sum

   // Address select; indexing wins only for low operands with access bit clear
   always_comb begin
      indexed_o = ext_en_i && !acc_bank_sel_i && (f_i <= iood_pkg::IDX_LIMIT);
      if (indexed_o) begin
         addr_o = iood_idx_sum(stack_frame_pointer_i, f_i);
      end else if (acc_bank_sel_i) begin
         addr_o = {bank_select_reg_i, f_i};
      end else if (f_i < iood_pkg::ACC_SPLIT) begin
         addr_o = {6'h00, f_i};
      end else begin
         addr_o = {iood_pkg::ACC_HI_PAGE, f_i};
      end
   end

endmodule : iood_addr_gen

/* verilog/iood_top.sv */
// Purpose: Indexed literal offset operand decoder with add, bit-set and fill-ones
// Assumes: One instruction presented per enabled cycle; read data valid with it
// Notes:   Results appear one clock after the instruction is taken
// Operation
// - Low operand, access clear: frame-pointer offset
// - Standard mode: literal access or banked address
// - Config bit enables indexing; add, bit-set and fill-ones decode in both modes
// - Operands above 5Fh stay literal access
// - Indexing applies to all access-bit instructions
// - Zero frame pointer gives original access addresses
// - Destination bit works as in standard mode
// - Add accumulator to indexed register, select destination
// - Add decoded from 0010 01d0 kkkk kkkk
// - Add updates N, OV, C, DC, Z; one cycle
// - Bit-set sets one bit, no flags
// - Bit-set decoded from 1000 bbb0 kkkk kkkk
// - Fill-ones writes FFh, one cycle, no flags
// - Fill-ones decoded from 0110 1000 kkkk kkkk
// - Config bit low: standard core behaviour
// - Frame pointer is fourteen bits wide
`timescale 1ns/1ps
module iood_top (
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic        ce_i,
   input  wire logic        extended_set_config_bit_i,
   input  wire logic        insn_valid_i,
   input  wire logic [15:0] insn_i,
   input  wire logic [13:0] stack_frame_pointer_i,
   input  wire logic [5:0]  bank_select_reg_i,
   input  wire logic [7:0]  wreg_i,
   input  wire logic [7:0]  rd_data_i,
   output logic [13:0]      addr_o,
   output logic             indexed_o,
   output logic             mem_we_o,
   output logic [7:0]       mem_wdata_o,
   output logic             wreg_we_o,
   output logic [7:0]       wreg_wdata_o,
   output logic             flags_we_o,
   output iood_pkg::iood_flags_type flags_o
);

   logic [7:0]               f_fld;
   logic                     acc_fld;
   logic [13:0]              ea;
   logic                     ea_idx;
   iood_pkg::iood_op_type    op_nxt;
   logic [8:0]               sum9;
   logic [4:0]               sum_lo;
   logic [7:0]               res;
   logic                     ext_en;
   logic                     d_fld;
   logic [2:0]               b_fld;

   assign f_fld   = insn_i[iood_pkg::OFS_HI:0];
   assign acc_fld = insn_i[iood_pkg::ACC_BIT];
   // Destination and bit-number fields, named once so the checks can sample them
   assign d_fld   = insn_i[iood_pkg::DEST_BIT];
   assign b_fld   = insn_i[iood_pkg::BIT_HI:iood_pkg::BIT_LO];
   // Mode enable is the config bit alone; it gates indexing only, while add, bit-set and fill-ones decode in both modes
   assign ext_en  = extended_set_config_bit_i;

   // Shared address former: every access-bit instruction goes through it
   iood_addr_gen u_addr (
      .f_i                   (f_fld),
      .acc_bank_sel_i        (acc_fld),
      .ext_en_i              (ext_en),
      .stack_frame_pointer_i (stack_frame_pointer_i),
      .bank_select_reg_i     (bank_select_reg_i),
      .addr_o                (ea),
      .indexed_o             (ea_idx)
   );

   // Opcode decode
   always_comb begin
      op_nxt = iood_pkg::IOOD_OP_NONE;
      if (insn_valid_i) begin
         if (insn_i[iood_pkg::OP_HI:iood_pkg::OP6_LO] == iood_pkg::OPC_ADD6) begin
            op_nxt = iood_pkg::IOOD_OP_ADD;
         end else if (insn_i[iood_pkg::OP_HI:iood_pkg::OP4_LO] == iood_pkg::OPC_BSET4) begin
            op_nxt = iood_pkg::IOOD_OP_BSET;
         end else if (insn_i[iood_pkg::OP_HI:iood_pkg::OP8_LO] == iood_pkg::OPC_FILL8 ||
                      insn_i[iood_pkg::OP_HI:iood_pkg::OP8_LO] == iood_pkg::OPC_FILL8A) begin
            op_nxt = iood_pkg::IOOD_OP_FILL;
         end
      end
   end

   // Arithmetic: 9-bit sum for carry, low nibble sum for digit carry
   assign sum9   = {1'b0, wreg_i} + {1'b0, rd_data_i};
   assign sum_lo = {1'b0, wreg_i[3:0]} + {1'b0, rd_data_i[3:0]};

   // Result per operation
   always_comb begin
      unique case (op_nxt)
         iood_pkg::IOOD_OP_ADD:  res = sum9[7:0];
         iood_pkg::IOOD_OP_BSET: res = rd_data_i |
                                       (8'h01 << insn_i[iood_pkg::BIT_HI:iood_pkg::BIT_LO]);
         iood_pkg::IOOD_OP_FILL: res = iood_pkg::FILL_VAL;
         iood_pkg::IOOD_OP_NONE: res = rd_data_i;
      endcase
   end

   // Address and mode indication, registered for the memory stage
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         addr_o    <= iood_pkg::RST_ADDR;
         indexed_o <= 1'b0;
      end else if (ce_i && insn_valid_i) begin
         addr_o    <= ea;
         indexed_o <= ea_idx;
      end
   end

   // Write path; destination bit honoured unchanged in both modes
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mem_we_o     <= 1'b0;
         mem_wdata_o  <= iood_pkg::RST_BYTE;
         wreg_we_o    <= 1'b0;
         wreg_wdata_o <= iood_pkg::RST_BYTE;
      end else if (ce_i) begin
         mem_wdata_o  <= res;
         wreg_wdata_o <= res;
         unique case (op_nxt)
            iood_pkg::IOOD_OP_ADD: begin
               mem_we_o  <= insn_i[iood_pkg::DEST_BIT];
               wreg_we_o <= !insn_i[iood_pkg::DEST_BIT];
            end
            iood_pkg::IOOD_OP_BSET, iood_pkg::IOOD_OP_FILL: begin
               mem_we_o  <= 1'b1;
               wreg_we_o <= 1'b0;
            end
            iood_pkg::IOOD_OP_NONE: begin
               mem_we_o  <= 1'b0;
               wreg_we_o <= 1'b0;
            end
         endcase
      end
   end

   // Status flags: only add touches them, single cycle
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         flags_we_o <= 1'b0;
         flags_o    <= '0;
      end else if (ce_i) begin
         flags_we_o <= (op_nxt == iood_pkg::IOOD_OP_ADD);
         if (op_nxt == iood_pkg::IOOD_OP_ADD) begin
            flags_o.n                <= sum9[7];
            flags_o.z                <= (sum9[7:0] == 8'h00);
            flags_o.c                <= sum9[8];
            flags_o.digit_carry_flag <= sum_lo[4];
            // Same-sign operands giving opposite-sign result
            flags_o.overflow_flag    <= (wreg_i[7] == rd_data_i[7]) && (sum9[7] != wreg_i[7]);
         end
      end
   end

   // Checks, each one edge after the instruction is taken
   // Low operand in extended mode lands at pointer plus offset
   property p_idx_addr;
      @(posedge clk_i) disable iff (srst_i)
      ce_i && insn_valid_i && extended_set_config_bit_i && !acc_fld &&
         f_fld <= iood_pkg::IDX_LIMIT
      |=> indexed_o && addr_o == $past(stack_frame_pointer_i) + {6'h00, $past(f_fld)};
   endproperty
   a_idx_addr: assert property (p_idx_addr) else $error("indexed address wrong");

   // Standard mode with access bit set uses the bank register
   property p_std_bank;
      @(posedge clk_i) disable iff (srst_i)
      ce_i && insn_valid_i && !extended_set_config_bit_i && acc_fld
      |=> !indexed_o && addr_o == {$past(bank_select_reg_i), $past(f_fld)};
   endproperty
   a_std_bank: assert property (p_std_bank) else $error("banked address wrong");

   // Config bit low never indexes, so legacy code keeps its addresses
   property p_off_noidx;
      @(posedge clk_i) disable iff (srst_i)
      ce_i && insn_valid_i && !extended_set_config_bit_i |=> !indexed_o;
   endproperty
   a_off_noidx: assert property (p_off_noidx) else $error("indexing while disabled");

   // High operands keep their literal low byte
   property p_high_lit;
      @(posedge clk_i) disable iff (srst_i)
      ce_i && insn_valid_i && !acc_fld && f_fld > iood_pkg::IDX_LIMIT
      |=> !indexed_o && addr_o[7:0] == $past(f_fld);
   endproperty
   a_high_lit: assert property (p_high_lit) else $error("high operand redirected");

   // Destination bit picks exactly one target; data is the wrapped sum
   property p_add_dest;
      @(posedge clk_i) disable iff (srst_i)
      ce_i && op_nxt == iood_pkg::IOOD_OP_ADD
      |=> mem_we_o == $past(d_fld) && wreg_we_o != mem_we_o &&
          mem_wdata_o == $past(wreg_i) + $past(rd_data_i);
   endproperty
   a_add_dest: assert property (p_add_dest) else $error("add destination wrong");

   // Zero and negative follow the written result
   property p_add_flags;
      @(posedge clk_i) disable iff (srst_i)
      ce_i && op_nxt == iood_pkg::IOOD_OP_ADD
      |=> flags_we_o && flags_o.z == (wreg_wdata_o == 8'h00) && flags_o.n == wreg_wdata_o[7];
   endproperty
   a_add_flags: assert property (p_add_flags) else $error("add flags wrong");

   // Selected bit ends up set and no bit is cleared
   property p_bset;
      @(posedge clk_i) disable iff (srst_i)
      ce_i && op_nxt == iood_pkg::IOOD_OP_BSET
      |=> mem_we_o && !flags_we_o &&
          mem_wdata_o[$past(b_fld)] &&
          (mem_wdata_o | $past(rd_data_i)) == mem_wdata_o;
   endproperty
   a_bset: assert property (p_bset) else $error("bit set wrong");

   // Fill-ones writes all ones and leaves the accumulator alone
   property p_fill;
      @(posedge clk_i) disable iff (srst_i)
      ce_i && op_nxt == iood_pkg::IOOD_OP_FILL
      |=> mem_we_o && !wreg_we_o && !flags_we_o && mem_wdata_o == iood_pkg::FILL_VAL;
   endproperty
   a_fill: assert property (p_fill) else $error("fill ones wrong");

   // Zero pointer maps low operands onto their access addresses
   property p_zero_fp;
      @(posedge clk_i) disable iff (srst_i)
      ce_i && insn_valid_i && !acc_fld && stack_frame_pointer_i == 14'h0000 &&
         f_fld <= iood_pkg::IDX_LIMIT
      |=> addr_o == {6'h00, $past(f_fld)};
   endproperty
   a_zero_fp: assert property (p_zero_fp) else $error("zero pointer remap wrong");

   // Standard mode, access bit clear: low half on page zero, high half on top page
   property p_std_access;
      @(posedge clk_i) disable iff (srst_i)
      ce_i && insn_valid_i && !extended_set_config_bit_i && !acc_fld
      |=> !indexed_o && addr_o == {($past(f_fld) < iood_pkg::ACC_SPLIT) ? 6'h00 :
                                   iood_pkg::ACC_HI_PAGE, $past(f_fld)};
   endproperty
   a_std_access: assert property (p_std_access) else $error("access address wrong");

   // Access bit set always banks, whatever the mode
   property p_any_bank;
      @(posedge clk_i) disable iff (srst_i)
      ce_i && insn_valid_i && acc_fld
      |=> !indexed_o && addr_o == {$past(bank_select_reg_i), $past(f_fld)};
   endproperty
   a_any_bank: assert property (p_any_bank) else $error("access bit ignored");

   // Bit-set touches no bit but the selected one
   property p_bset_only;
      @(posedge clk_i) disable iff (srst_i)
      ce_i && op_nxt == iood_pkg::IOOD_OP_BSET
      |=> ((mem_wdata_o ^ $past(rd_data_i)) & ~(8'h01 << $past(b_fld))) == 8'h00 &&
          !wreg_we_o;
   endproperty
   a_bset_only: assert property (p_bset_only) else $error("other bits changed");

   // Carry and digit carry rebuilt from the operands, not from the sum path
   property p_add_carry;
      @(posedge clk_i) disable iff (srst_i)
      ce_i && op_nxt == iood_pkg::IOOD_OP_ADD
      |=> flags_o.c == ({1'b0, $past(wreg_i)} + {1'b0, $past(rd_data_i)} > 9'h0FF) &&
          flags_o.digit_carry_flag ==
             (($past(wreg_i) & 8'h0F) + ($past(rd_data_i) & 8'h0F) > 8'h0F);
   endproperty
   a_add_carry: assert property (p_add_carry) else $error("add carry flags wrong");

   // Overflow when the result sign differs from both operand signs
   property p_add_ovf;
      @(posedge clk_i) disable iff (srst_i)
      ce_i && op_nxt == iood_pkg::IOOD_OP_ADD
      |=> flags_o.overflow_flag ==
          ((($past(wreg_i) ^ wreg_wdata_o) &
            ($past(rd_data_i) ^ wreg_wdata_o) & 8'h80) != 8'h00);
   endproperty
   a_add_ovf: assert property (p_add_ovf) else $error("overflow flag wrong");

   // Flags hold across every instruction but add
   property p_flags_hold;
      @(posedge clk_i) disable iff (srst_i)
      ce_i && op_nxt != iood_pkg::IOOD_OP_ADD
      |=> !flags_we_o && $stable(flags_o);
   endproperty
   a_flags_hold: assert property (p_flags_hold) else $error("flags moved");

   // Enable low freezes address, both write enables, memory write data and flags, held write pulses included
   property p_ce_freeze;
      @(posedge clk_i) disable iff (srst_i)
      !ce_i
      |=> $stable(addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o) &&
          $stable(wreg_we_o) && $stable(flags_o);
   endproperty
   a_ce_freeze: assert property (p_ce_freeze) else $error("moved while frozen");

   // No instruction, no writes; the last address stands
   property p_idle;
      @(posedge clk_i) disable iff (srst_i)
      ce_i && !insn_valid_i
      |=> !mem_we_o && !wreg_we_o && !flags_we_o &&
          $stable(addr_o) && $stable(indexed_o);
   endproperty
   a_idle: assert property (p_idle) else $error("write without instruction");

endmodule : iood_top

/* dv/iood_mem_model.sv */
// Purpose: Data memory model on the far side of the operand decoder
// Assumes: Reads answer in the same cycle, writes land on the rising edge
// Notes:   Seeded with a fixed pattern so sums are predictable
`timescale 1ns/1ps
module iood_mem_model (
   input  wire logic        clk_i,
   input  wire logic [13:0] rd_addr_i,
   output logic [7:0]       rd_data_o,
   input  wire logic [13:0] wr_addr_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  wdata_i
);
   logic [7:0] mem_r [0:16383];

   // Seed pattern, nonzero where the flag cases look
   initial begin
      for (int i = 0; i < 16384; i++) begin
         mem_r[i] = 8'(i) ^ 8'hA5;
      end
   end

   // Same-cycle read, as the fetch stage presents it
   assign rd_data_o = mem_r[rd_addr_i];

   // Commit whatever the decoder writes; a held pulse rewrites the same byte
   always @(posedge clk_i) begin
      if (we_i) begin
         mem_r[wr_addr_i] <= wdata_i;
      end
   end
endmodule : iood_mem_model

/* dv/testbench.sv */
// Purpose: Self-checking bench for the indexed offset operand decoder
// Assumes: Results stand one edge after the instruction is taken
// Notes:   Each issue call checks the previous instruction's results
`timescale 1ns/1ps
module testbench;
   logic clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, ext_r = 1'b0, valid_r = 1'b0;
   logic [15:0] insn_r = 16'h0000;
   logic [13:0] fp_r = 14'h0000, rd_addr = 14'h0000, addr_o, p_addr;
   logic [5:0]  bsr_r = 6'h00;
   logic [7:0]  w_r = 8'h00, rd_data, mem_wdata_o, wreg_wdata_o, p_wd;
   logic        indexed_o, mem_we_o, wreg_we_o, flags_we_o, p_idx, p_mwe, p_wwe, p_fwe;
   iood_pkg::iood_flags_type flags_o, p_fl;
   int          fail_count = 0;
   int          num_checks = 0;

   always #4 clk_i = ~clk_i;

   iood_top u_dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
      .extended_set_config_bit_i(ext_r), .insn_valid_i(valid_r), .insn_i(insn_r),
      .stack_frame_pointer_i(fp_r), .bank_select_reg_i(bsr_r), .wreg_i(w_r),
      .rd_data_i(rd_data), .addr_o(addr_o), .indexed_o(indexed_o), .mem_we_o(mem_we_o),
      .mem_wdata_o(mem_wdata_o), .wreg_we_o(wreg_we_o), .wreg_wdata_o(wreg_wdata_o),
      .flags_we_o(flags_we_o), .flags_o(flags_o));
   iood_mem_model u_mem (.clk_i(clk_i), .rd_addr_i(rd_addr), .rd_data_o(rd_data),
      .wr_addr_i(addr_o), .we_i(mem_we_o), .wdata_i(mem_wdata_o));

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // Bit 14 marks a frame-pointer address; sum wraps in 14 bits
   function automatic logic [14:0] ea(input logic e, input logic [15:0] ins,
                                      input logic [13:0] fp, input logic [5:0] bank_select_reg);
      if (e && !ins[8] && ins[7:0] <= 8'h5F) return {1'b1, fp + {6'h00, ins[7:0]}};
      if (ins[8]) return {1'b0, bank_select_reg, ins[7:0]};
      return {1'b0, (ins[7:0] >= 8'h60) ? 6'h3F : 6'h00, ins[7:0]};
   endfunction : ea

   task automatic verify;
      chk("addr", 16'(addr_o), 16'(p_addr));
      chk("indexed", 16'(indexed_o), 16'(p_idx));
      chk("mem_we", 16'(mem_we_o), 16'(p_mwe));
      chk("wreg_we", 16'(wreg_we_o), 16'(p_wwe));
      chk("flags_we", 16'(flags_we_o), 16'(p_fwe));
      chk("flags", 16'(flags_o), 16'(p_fl));
      if (p_mwe || p_wwe) begin
         chk("mem_wdata", 16'(mem_wdata_o), 16'(p_wd));
         chk("wreg_wdata", 16'(wreg_wdata_o), 16'(p_wd));
      end
   endtask : verify

   // Drive one instruction, check the last one, then predict this one
   task automatic issue(input logic v, input logic e, input logic [15:0] ins,
                        input logic [13:0] fp, input logic [5:0] bank_select_reg, input logic [7:0] w);
      logic [14:0] a;
      logic [8:0]  s;
      logic [4:0]  ln;
      a = ea(e, ins, fp, bank_select_reg);
      @(posedge clk_i);
      valid_r <= v; ext_r <= e; insn_r <= ins; fp_r <= fp; bsr_r <= bank_select_reg; w_r <= w;
      rd_addr <= a[13:0];
      #1;
      verify();
      {p_mwe, p_wwe, p_fwe} = 3'b000;
      if (v) begin
         {p_idx, p_addr} = a;
         if (ins[15:10] == 6'h09) begin
            s = w + rd_data;
            ln = w[3:0] + rd_data[3:0];
            {p_wd, p_mwe, p_wwe, p_fwe} = {s[7:0], ins[9], !ins[9], 1'b1};
            p_fl = {s[7], (w[7] == rd_data[7]) && (s[7] != w[7]), s[7:0] == 8'h00, ln[4], s[8]};
         end else if (ins[15:12] == 4'h8) begin
            {p_wd, p_mwe} = {rd_data | (8'h01 << ins[11:9]), 1'b1};
         end else if (ins[15:9] == 7'h34) begin
            {p_wd, p_mwe} = {8'hFF, 1'b1};
         end
      end
   endtask : issue

   // Check the pending result, then hold reset for n more edges
   task automatic do_reset(input int n);
      @(posedge clk_i);
      srst_i <= 1'b1;
      valid_r <= 1'b0;
      #1;
      verify();
      {p_addr, p_idx, p_mwe, p_wwe, p_fwe, p_wd, p_fl} = '0;
      repeat (n) @(posedge clk_i);
      srst_i <= 1'b0;
      #1;
      verify();
   endtask : do_reset

   task automatic print_verdict;
      $display("Checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict

   // Whole run is under fifty cycles
   initial begin
      #(8 * 3000);
      fail_count++;
      print_verdict();
   end

   initial begin
      {p_addr, p_idx, p_mwe, p_wwe, p_fwe, p_wd, p_fl} = '0;
      do_reset(15);
      // Addressing forms, back to back, config bit set for indexed code
      issue(1, 1, 16'h2605, 14'h0A00, 6'h00, 8'h17);
      issue(1, 1, 16'h245F, 14'h3FF0, 6'h00, 8'h01);
      issue(1, 1, 16'h2460, 14'h0A00, 6'h00, 8'h02);
      issue(1, 0, 16'h2405, 14'h0A00, 6'h00, 8'h03);
      issue(1, 0, 16'h2505, 14'h0A00, 6'h12, 8'h04);
      issue(1, 1, 16'h2505, 14'h0A00, 6'h12, 8'h05);
      issue(1, 1, 16'h2420, 14'h0000, 6'h00, 8'h06);
      $display("Test addressing done");
      // Flag corners: zero with carry, then overflow with digit carry
      issue(1, 1, 16'h2410, 14'h0100, 6'h00, 8'h00 - u_mem.mem_r[14'h0110]);
      issue(1, 1, 16'h2650, 14'h0A30, 6'h00, 8'h7F);
      $display("Test flags done");
      // Every bit number indexed, then bit 7 banked
      for (int b = 0; b < 8; b++) begin
         issue(1, 1, {4'h8, 3'(b), 1'b0, 8'h0A}, 14'h0A00, 6'h00, 8'h00);
      end
      issue(1, 0, 16'h8F33, 14'h0A00, 6'h05, 8'h00);
      $display("Test bit set done");
      issue(1, 1, 16'h682C, 14'h0A00, 6'h00, 8'h00);
      issue(1, 1, 16'h0000, 14'h0A00, 6'h00, 8'h00);
      issue(1, 0, 16'h6905, 14'h0A00, 6'h21, 8'h00);
      // Clock enable low freezes the held fill pulse and refuses a new one
      @(posedge clk_i);
      ce_i <= 1'b0;
      insn_r <= 16'h8A10;
      #1;
      verify();
      repeat (2) begin
         @(posedge clk_i);
         #1;
         verify();
      end
      @(posedge clk_i);
      ce_i <= 1'b1;
      valid_r <= 1'b0;
      #1;
      verify();
      {p_mwe, p_wwe, p_fwe} = 3'b000;
      $display("Test fill and freeze done");
      issue(1, 1, 16'h2604, 14'h0200, 6'h00, 8'h11);
      do_reset(1);
      issue(1, 1, 16'h6801, 14'h0300, 6'h00, 8'h00);
      issue(0, 0, 16'h0000, 14'h0000, 6'h00, 8'h00);
      issue(0, 0, 16'h0000, 14'h0000, 6'h00, 8'h00);
      $display("Test reset done");
      print_verdict();
   end
endmodule : testbench
